// ---- logic/timer_pwm_consts.vh ----
`ifndef TIMER_PWM_CONSTS_VH
`define TIMER_PWM_CONSTS_VH

// register offsets
`define CH2_MODE_OFS     12'hf90
`define CH2_CTRL_OFS     12'hf94
`define CH2_STATUS_OFS   12'hf96
`define LOW_LIMIT_OFS    12'hf98
`define HIGH_LIMIT_OFS   12'hf9a
`define CH2_COUNT_OFS    12'hf9c
`define CH1_MODE_OFS     12'hfa8
`define CH1_LIMIT_OFS    12'hfaa
`define CH1_COUNT_OFS    12'hfac

// mode register fields
`define SEL_LO_BIT       0
`define SEL_HI_BIT       1
`define RUN_BIT          2
`define START_BIT        3
`define CLK_SEL_LSB      4
`define CLK_SEL_MSB      6
`define MODE_WMASK       8'h7f

// control register fields
`define CH1_OE_BIT       2
`define CH2_OE_BIT       3

// status register fields
`define IRQ_BIT          0

// write lane masks
`define MASK_FULL        8'hff
`define MASK_START       8'h08

// mode select codes (sel_hi, sel_lo)
`define MODE_PWM         2'h1
`define MODE_CASCADE     2'h2

// count pulse select codes
`define CP_SEL_2         3'h2
`define CP_SEL_3         3'h3
`define CP_SEL_4         3'h4
`define CP_SEL_5         3'h5
`define CP_SEL_6         3'h6
`define CP_SEL_7         3'h7

// reset values and counter maximum
`define MODE_RESET       8'h00
`define CTRL_RESET       8'h00
`define LIMIT_RESET      8'h00
`define COUNT_RESET      8'h00
`define COUNT_MAX        8'hff

// prescaler width
`define DIV_STAGES       12

`endif

// ---- logic/rate_divider.v ----
`timescale 1ns/1ps
`include "timer_pwm_consts.vh"

module rate_divider #(
  parameter STAGES = `DIV_STAGES
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              reset_n,
  // tick[k] pulses once every 2^(k+1) clocks
  output wire [STAGES-1:0] tick
);

  reg [STAGES-1:0] div_reg;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      div_reg <= {STAGES{1'b0}};
    end else begin
      div_reg <= div_reg + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  genvar k;
  generate
    for (k = 0; k < STAGES; k = k + 1) begin : g_tick
      assign tick[k] = &div_reg[k:0];
    end
  endgenerate

endmodule // rate_divider

// ---- logic/timer_pwm.v ----
`timescale 1ns/1ps
`include "timer_pwm_consts.vh"

//Contract
// - sel_hi,sel_lo = 0,1 selects PWM mode
// - control register cleared by reset
// - pin low unless output enable set
// - separate high and low period limits
// - high match toggles, switches to low
// - low match sets flag, toggles, switches back
// - high and low periods alternate endlessly
// - channel 2 clock select decode
// - channel 1 clock select decode
// - start clears counter and flag
// - mode registers take whole byte or start-bit-only writes, start bit self-clears
// - both mode registers reset to zero
// - control register 8, 4, 1 bit access
// - cascade makes one 16-bit timer
// - channel 1 enable governs its output
// - run bit zero holds count
// - cascade select is 1,0 and 1,0
module timer_pwm (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // register port
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire [7:0]  reg_wmask,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // pins
  output reg         ch2_pulse_pin,
  output reg         ch1_pulse_pin,
  // event outputs
  output reg         ch2_interrupt,
  output wire        ch2_irq_flag
);

  // registers
  reg  [7:0] ch2_mode_control_reg;
  reg  [7:0] ch1_mode_control_reg;
  reg  [7:0] ch2_control_reg;
  reg  [7:0] high_period_limit_reg;
  reg  [7:0] low_period_limit_reg;
  reg  [7:0] ch1_limit_reg;
  reg  [7:0] ch2_counter_reg;
  reg  [7:0] ch1_counter_reg;
  reg        ch2_irq_flag_reg;
  reg        output_toggle_flop_reg;
  reg        low_phase_reg;

  // prescaler ticks
  wire [`DIV_STAGES-1:0] tick;

  // decoded bus strobes
  wire       wr_ch2_mode;
  wire       wr_ch1_mode;
  wire       wr_ctrl;
  wire       wr_status;
  wire       mode_full;
  wire       mode_start_only;
  wire       start2;
  wire       start1;

  // mode decode
  wire [1:0] ch2_sel;
  wire [1:0] ch1_sel;
  wire       pwm_mode;
  wire       cascade_mode;
  wire       ch2_run;
  wire       ch1_run;
  wire       ch2_output_enable;
  wire       ch1_output_enable;
  wire [2:0] ch2_clk_sel;
  wire [2:0] ch1_clk_sel;

  // count pulses and matches
  reg        count_pulse2;
  reg        count_pulse1;
  wire       ch2_overflow;
  wire [7:0] active_limit;
  wire       pwm_match;
  wire       cascade_match;
  wire       irq_set;

  rate_divider #(
    .STAGES (`DIV_STAGES)
  ) rate_divider_i (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  assign wr_ch2_mode = reg_wr && (reg_addr == `CH2_MODE_OFS);
  assign wr_ch1_mode = reg_wr && (reg_addr == `CH1_MODE_OFS);
  assign wr_ctrl     = reg_wr && (reg_addr == `CH2_CTRL_OFS);
  assign wr_status   = reg_wr && (reg_addr == `CH2_STATUS_OFS);

  assign mode_full       = (reg_wmask == `MASK_FULL);
  assign mode_start_only = (reg_wmask == `MASK_START);
  assign start2 = wr_ch2_mode && (mode_full || mode_start_only)
                  && reg_wdata[`START_BIT];
  assign start1 = wr_ch1_mode && (mode_full || mode_start_only)
                  && reg_wdata[`START_BIT];

  assign ch2_sel = {ch2_mode_control_reg[`SEL_HI_BIT],
                    ch2_mode_control_reg[`SEL_LO_BIT]};
  assign ch1_sel = {ch1_mode_control_reg[`SEL_HI_BIT],
                    ch1_mode_control_reg[`SEL_LO_BIT]};
  assign pwm_mode     = (ch2_sel == `MODE_PWM);
  assign cascade_mode = (ch2_sel == `MODE_CASCADE)
                        && (ch1_sel == `MODE_CASCADE);
  assign ch2_run = ch2_mode_control_reg[`RUN_BIT];
  assign ch1_run = ch1_mode_control_reg[`RUN_BIT];
  assign ch2_output_enable = ch2_control_reg[`CH2_OE_BIT];
  assign ch1_output_enable = ch2_control_reg[`CH1_OE_BIT];
  assign ch2_clk_sel =
    ch2_mode_control_reg[`CLK_SEL_MSB:`CLK_SEL_LSB];
  assign ch1_clk_sel =
    ch1_mode_control_reg[`CLK_SEL_MSB:`CLK_SEL_LSB];

  // channel 2 count pulse select
  always @* begin
    case (ch2_clk_sel)
      `CP_SEL_2: count_pulse2 = tick[0];
      `CP_SEL_3: count_pulse2 = 1'b1;
      `CP_SEL_4: count_pulse2 = tick[9];
      `CP_SEL_5: count_pulse2 = tick[7];
      `CP_SEL_6: count_pulse2 = tick[5];
      `CP_SEL_7: count_pulse2 = tick[3];
      default:   count_pulse2 = 1'b0;
    endcase
  end

  assign ch2_overflow = count_pulse2 && ch2_run
                        && (ch2_counter_reg == `COUNT_MAX);

  // channel 1 count pulse select
  always @* begin
    case (ch1_clk_sel)
      `CP_SEL_2: count_pulse1 = ch2_overflow;
      `CP_SEL_3: count_pulse1 = tick[4];
      `CP_SEL_4: count_pulse1 = tick[11];
      `CP_SEL_5: count_pulse1 = tick[9];
      `CP_SEL_6: count_pulse1 = tick[7];
      `CP_SEL_7: count_pulse1 = tick[5];
      default:   count_pulse1 = 1'b0;
    endcase
  end

  // compare against the limit of the current phase
  assign active_limit = low_phase_reg ? low_period_limit_reg
                                      : high_period_limit_reg;
  assign pwm_match = pwm_mode && ch2_run && count_pulse2
                     && (ch2_counter_reg == active_limit);
  assign cascade_match = cascade_mode && ch2_run && count_pulse2
                         && (ch2_counter_reg == low_period_limit_reg)
                         && (ch1_counter_reg == ch1_limit_reg);
  assign irq_set = (pwm_match && low_phase_reg) || cascade_match;

  // channel 2 mode register
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_mode_control_reg <= `MODE_RESET;
    end else if (wr_ch2_mode && mode_full) begin
      ch2_mode_control_reg <= reg_wdata & `MODE_WMASK;
    end else if (wr_ch2_mode && mode_start_only) begin
      ch2_mode_control_reg[`START_BIT] <= reg_wdata[`START_BIT];
    end else if (ch2_mode_control_reg[`START_BIT]) begin
      ch2_mode_control_reg[`START_BIT] <= 1'b0;
    end
  end

  // channel 1 mode register
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch1_mode_control_reg <= `MODE_RESET;
    end else if (wr_ch1_mode && mode_full) begin
      ch1_mode_control_reg <= reg_wdata & `MODE_WMASK;
    end else if (wr_ch1_mode && mode_start_only) begin
      ch1_mode_control_reg[`START_BIT] <= reg_wdata[`START_BIT];
    end else if (ch1_mode_control_reg[`START_BIT]) begin
      ch1_mode_control_reg[`START_BIT] <= 1'b0;
    end
  end

  // control register, lane masked
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_control_reg <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ch2_control_reg <= (ch2_control_reg & ~reg_wmask)
                         | (reg_wdata & reg_wmask);
    end
  end

  // limit registers
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      high_period_limit_reg <= `LIMIT_RESET;
      low_period_limit_reg  <= `LIMIT_RESET;
      ch1_limit_reg         <= `LIMIT_RESET;
    end else if (reg_wr && (reg_wmask == `MASK_FULL)) begin
      if (reg_addr == `HIGH_LIMIT_OFS) begin
        high_period_limit_reg <= reg_wdata;
      end
      if (reg_addr == `LOW_LIMIT_OFS) begin
        low_period_limit_reg <= reg_wdata;
      end
      if (reg_addr == `CH1_LIMIT_OFS) begin
        ch1_limit_reg <= reg_wdata;
      end
    end
  end

  // channel 2 counter and phase
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_counter_reg <= `COUNT_RESET;
      low_phase_reg   <= 1'b0;
    end else if (start2) begin
      ch2_counter_reg <= `COUNT_RESET;
      low_phase_reg   <= 1'b0;
    end else if (pwm_match) begin
      ch2_counter_reg <= `COUNT_RESET;
      low_phase_reg   <= ~low_phase_reg;
    end else if (cascade_match) begin
      ch2_counter_reg <= `COUNT_RESET;
    end else if (ch2_run && count_pulse2
                 && (pwm_mode || cascade_mode)) begin
      ch2_counter_reg <= ch2_counter_reg + 8'h01;
    end
  end

  // channel 1 counter, cascade upper byte
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch1_counter_reg <= `COUNT_RESET;
    end else if (start1 || start2) begin
      ch1_counter_reg <= `COUNT_RESET;
    end else if (cascade_match) begin
      ch1_counter_reg <= `COUNT_RESET;
    end else if (cascade_mode && ch1_run && count_pulse1) begin
      ch1_counter_reg <= ch1_counter_reg + 8'h01;
    end
  end

  // output toggle flop
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      output_toggle_flop_reg <= 1'b0;
    end else if (start2) begin
      output_toggle_flop_reg <= 1'b0;
    end else if (pwm_match || cascade_match) begin
      output_toggle_flop_reg <= ~output_toggle_flop_reg;
    end
  end

  // interrupt flag, set wins over software clear
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_irq_flag_reg <= 1'b0;
    end else if (start2) begin
      ch2_irq_flag_reg <= 1'b0;
    end else if (irq_set) begin
      ch2_irq_flag_reg <= 1'b1;
    end else if (wr_status && reg_wmask[`IRQ_BIT]
                 && reg_wdata[`IRQ_BIT]) begin
      ch2_irq_flag_reg <= 1'b0;
    end
  end

  assign ch2_irq_flag = ch2_irq_flag_reg;

  // interrupt request pulse
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_interrupt <= 1'b0;
    end else begin
      ch2_interrupt <= irq_set && !start2;
    end
  end

  // pins
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ch2_pulse_pin <= 1'b0;
      ch1_pulse_pin <= 1'b0;
    end else begin
      ch2_pulse_pin <= ch2_output_enable
                       && output_toggle_flop_reg;
      ch1_pulse_pin <= cascade_mode && ch1_output_enable
                       && output_toggle_flop_reg;
    end
  end

  // read data, one cycle after the strobe
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CH2_MODE_OFS:   reg_rdata <= ch2_mode_control_reg;
        `CH1_MODE_OFS:   reg_rdata <= ch1_mode_control_reg;
        `CH2_CTRL_OFS:   reg_rdata <= ch2_control_reg;
        `CH2_STATUS_OFS: reg_rdata <= {7'h00, ch2_irq_flag_reg};
        `HIGH_LIMIT_OFS: reg_rdata <= high_period_limit_reg;
        `LOW_LIMIT_OFS:  reg_rdata <= low_period_limit_reg;
        `CH1_LIMIT_OFS:  reg_rdata <= ch1_limit_reg;
        `CH2_COUNT_OFS:  reg_rdata <= ch2_counter_reg;
        `CH1_COUNT_OFS:  reg_rdata <= ch1_counter_reg;
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // timer_pwm

// ---- testbench/timer_pwm_monitor.sv ----
`timescale 1ns/1ps
module timer_pwm_monitor (
  // clock and reset
  input wire        ref_clk,
  input wire        reset_n,
  // register port
  input wire [11:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_wmask,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // pins and events
  input wire        ch2_pulse_pin,
  input wire        ch1_pulse_pin,
  input wire        ch2_interrupt,
  input wire        ch2_irq_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // start command write, whole byte or start bit alone
  wire start_wr = reg_wr && reg_addr == 12'hf90 && reg_wdata[3] && (reg_wmask == 8'hff || reg_wmask == 8'h08);

  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !ch2_pulse_pin && !ch1_pulse_pin && !ch2_irq_flag)
    else $error("outputs not quiet after reset");
  a_start_clears_flag: assert property (start_wr |=> !ch2_irq_flag)
    else $error("flag survived start");
  a_start_pin_low: assert property (start_wr |-> ##2 !ch2_pulse_pin)
    else $error("pin not low after start");
  a_start_self_clear: assert property (start_wr ##2 (reg_rd && reg_addr == 12'hf90) |=> !reg_rdata[3])
    else $error("start bit did not self clear");
  a_level_min_two: assert property ($changed(ch2_pulse_pin) && !reg_wr && !$past(reg_wr) |=> $stable(ch2_pulse_pin))
    else $error("pin level shorter than two cycles");
  a_irq_pulse: assert property ($rose(ch2_irq_flag) |-> ##[0:1] ch2_interrupt)
    else $error("flag rose without interrupt pulse");
  a_irq_one_cycle: assert property (ch2_interrupt |=> !ch2_interrupt)
    else $error("interrupt longer than one cycle");
  a_flag_sticky: assert property ($fell(ch2_irq_flag) |-> $past(reg_wr))
    else $error("flag fell without a write");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule // timer_pwm_monitor

bind timer_pwm timer_pwm_monitor timer_pwm_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ch2_pulse_pin(ch2_pulse_pin), .ch1_pulse_pin(ch1_pulse_pin), .ch2_interrupt(ch2_interrupt),
  .ch2_irq_flag(ch2_irq_flag));

// ---- testbench/pin_load.sv ----
`timescale 1ns/1ps
module pin_load (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // driven pin
  input  wire        pin,
  // measured run lengths in clocks, and edge count
  output reg  [15:0] hi_len,
  output reg  [15:0] lo_len,
  output reg  [15:0] edges
);
  reg        last_reg;
  reg [15:0] run_reg;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      last_reg <= 1'b0;
      run_reg  <= 16'h0001;
      hi_len   <= 16'h0000;
      lo_len   <= 16'h0000;
      edges    <= 16'h0000;
    end else if (pin !== last_reg) begin
      last_reg <= pin;
      run_reg  <= 16'h0001;
      edges    <= edges + 16'h0001;
      if (last_reg) hi_len <= run_reg;
      else lo_len <= run_reg;
    end else begin
      run_reg <= run_reg + 16'h0001;
    end
  end
endmodule // pin_load

// ---- testbench/timer_pwm_and_cascade_setup_test.sv ----
`timescale 1ns/1ps
module timer_pwm_and_cascade_setup_test;
  reg         ref_clk   = 1'b0;
  reg         reset_n   = 1'b0;
  reg  [11:0] reg_addr  = 12'h000;
  reg  [7:0]  reg_wdata = 8'h00;
  reg  [7:0]  reg_wmask = 8'h00;
  reg         reg_wr    = 1'b0;
  reg         reg_rd    = 1'b0;
  wire [7:0]  reg_rdata;
  wire        ch2_pulse_pin;
  wire        ch1_pulse_pin;
  wire        ch2_interrupt;
  wire        ch2_irq_flag;
  wire [15:0] hi_len;
  wire [15:0] lo_len;
  wire [15:0] edges;
  integer     errors = 0;
  integer     check_count = 0;
  integer     ints = 0;
  integer     dv [0:5] = '{2, 1, 1024, 256, 64, 16};
  reg  [7:0]  rv;
  reg  [7:0]  rv2;
  integer     i;
  integer     e0;

  timer_pwm timer_pwm_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wmask(reg_wmask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch2_pulse_pin(ch2_pulse_pin),
    .ch1_pulse_pin(ch1_pulse_pin), .ch2_interrupt(ch2_interrupt), .ch2_irq_flag(ch2_irq_flag));
  pin_load pin_load_i (.ref_clk(ref_clk), .reset_n(reset_n), .pin(ch2_pulse_pin), .hi_len(hi_len),
    .lo_len(lo_len), .edges(edges));

  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ch2_interrupt === 1'b1) ints <= ints + 1;

  task chk(input string name, input [15:0] seen, input [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d, input [7:0] m);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wmask <= m;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input [11:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task wait_edges(input integer n);
    integer k;
    @(negedge ref_clk);
    e0 = edges;
    for (k = 0; k < 20000 && edges < e0 + n; k = k + 1) @(posedge ref_clk);
  endtask
  task t_reset;
    rd(12'hf90, rv); chk("ch2 mode", rv, 8'h00);
    rd(12'hfa8, rv); chk("ch1 mode", rv, 8'h00);
    rd(12'hf94, rv); chk("ctrl", rv, 8'h00);
    rd(12'hf92, rv); chk("unmapped", rv, 8'h00);
    wr(12'hfa8, 8'hf0, 8'hff);
    rd(12'hfa8, rv); chk("ch1 byte", rv, 8'h70);
    wr(12'hfa8, 8'h00, 8'hff);
    $display("test reset done");
  endtask
  task t_rates;
    wr(12'hf9a, 8'h01, 8'hff);
    wr(12'hf98, 8'h02, 8'hff);
    wr(12'hf94, 8'h08, 8'h08);
    for (i = 0; i < 6; i = i + 1) begin
      wr(12'hf90, {1'b0, i[2:0] + 3'h2, 4'hd}, 8'hff);
      wait_edges(5);
      chk("high width", hi_len, 3 * dv[i]);
      chk("low width", lo_len, 2 * dv[i]);
    end
    rd(12'hf96, rv); chk("flag set", rv[0], 1'b1);
    chk("int seen", ints > 0, 1'b1);
    $display("test rates done");
  endtask
  task t_stop;
    wr(12'hf90, 8'h71, 8'hff);
    rd(12'hf9c, rv);
    repeat (40) @(posedge ref_clk);
    rd(12'hf9c, rv2); chk("held count", rv2, rv);
    wr(12'hf90, 8'h08, 8'h08);
    rd(12'hf9c, rv); chk("start count", rv, 8'h00);
    rd(12'hf96, rv); chk("start flag", rv[0], 1'b0);
    $display("test stop done");
  endtask
  task t_flag_low;
    wr(12'hf98, 8'h40, 8'hff);
    wr(12'hf90, 8'h3d, 8'hff);
    rd(12'hf90, rv); chk("mode after start", rv, 8'h35);
    repeat (10) @(posedge ref_clk);
    chk("pin after high", ch2_pulse_pin, 1'b1);
    rd(12'hf96, rv); chk("no flag on high", rv[0], 1'b0);
    $display("test flag done");
  endtask
  task t_oe;
    wr(12'hf94, 8'h00, 8'h0f);
    repeat (3) @(posedge ref_clk);
    e0 = edges;
    repeat (200) @(posedge ref_clk);
    chk("edges when off", edges, e0);
    chk("pin when off", ch2_pulse_pin, 1'b0);
    rd(12'hf94, rv); chk("ctrl nibble", rv, 8'h00);
    $display("test enable done");
  endtask
  task t_cascade;
    wr(12'hfaa, 8'h01, 8'hff);
    wr(12'hf98, 8'h02, 8'hff);
    wr(12'hf94, 8'h0c, 8'hff);
    wr(12'hfa8, 8'h26, 8'hff);
    wr(12'hf90, 8'h3e, 8'hff);
    wait_edges(5);
    chk("cascade high", hi_len, 16'h0103);
    chk("cascade low", lo_len, 16'h0103);
    rd(12'hf96, rv); chk("cascade flag", rv[0], 1'b1);
    chk("flag pin", ch2_irq_flag, 1'b1);
    @(negedge ref_clk);
    while (ch2_pulse_pin !== 1'b1) @(negedge ref_clk);
    chk("ch1 pin on", ch1_pulse_pin, 1'b1);
    wr(12'hf94, 8'h00, 8'h04);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    while (ch2_pulse_pin !== 1'b1) @(negedge ref_clk);
    chk("ch1 pin off", ch1_pulse_pin, 1'b0);
    $display("test cascade done");
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #360000;
    errors = errors + 1;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_rates;
    t_stop;
    t_flag_low;
    t_oe;
    t_cascade;
    wrap_up;
  end
endmodule // timer_pwm_and_cascade_setup_test
